// *** src/sscp_pkg.sv ***
// shared constants and types for the strap and serial config port
package sscp_pkg;
	// clock and bus timing
	localparam int CLK_MHZ         = 100;
	localparam int T_BUF_NS        = 4700;
	localparam int T_HIGH_MAX_NS   = 50000;
	localparam int T_BUF_CYC       = (T_BUF_NS * CLK_MHZ + 999) / 1000;
	localparam int T_HIGH_MAX_CYC  = (T_HIGH_MAX_NS * CLK_MHZ) / 1000;
	localparam int VALID_HOLD_CYC  = 110;
	// bus address and device registers
	localparam logic [6:0] SLAVE_ADDR  = 7'h57;
	localparam logic [7:0] REG_CODING  = 8'h21;
	localparam logic [7:0] REG_UNLOCK  = 8'h22;
	localparam logic [7:0] CODING_RST  = 8'h00;
	localparam logic [7:0] UNLOCK_RST  = 8'h00;
	localparam int SCR_BIT      = 4;
	localparam int NRZI_BIT     = 7;
	localparam int SCR_UNLK_BIT = 3;
	localparam int NRZI_OVR_BIT = 4;
	// host controller register offsets and fields
	localparam logic [7:0] HR_CMD    = 8'h00;
	localparam logic [7:0] HR_STATUS = 8'h04;
	localparam logic [7:0] HR_LINK   = 8'h08;
	localparam logic [7:0] HR_LANE   = 8'h0C;
	localparam int CMD_GO    = 0;
	localparam int CMD_READ  = 1;
	localparam int CMD_REG_L = 8;
	localparam int CMD_DAT_L = 16;
	localparam int LNK_START = 0;
	localparam int LNK_PER   = 1;
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_ADDR = 3'b001,
		D_ACK  = 3'b010,
		D_RX   = 3'b011,
		D_TX   = 3'b100,
		D_MACK = 3'b101,
		D_IGN  = 3'b110
	} sscp_dst_t;
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_SEL   = 3'b001,
		H_START = 3'b010,
		H_BIT   = 3'b011,
		H_STOP  = 3'b100,
		H_DESEL = 3'b101
	} sscp_hst_t;
endpackage

// *** src/sscp_if.sv ***
// link between the host controller and the serializer config port
`timescale 1ns/1ps
interface sscp_if;
	logic       scl_o;
	logic       scl_oe;
	logic       sda_h_o;
	logic       sda_h_oe;
	logic       sda_d_o;
	logic       sda_d_oe;
	logic       bus_port_select;
	logic [3:0] lane_data;
	logic       valid_lane_input;
	logic       scl;
	logic       sda;
	// open-drain wires with pull-ups
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
	modport dev(input scl, sda, bus_port_select, lane_data, valid_lane_input,
		output sda_d_o, sda_d_oe);
	modport host(input scl, sda, output scl_o, scl_oe, sda_h_o, sda_h_oe,
		bus_port_select, lane_data, valid_lane_input);
endinterface

// *** src/sscp_dev.sv ***
// serializer end: strap decode, coding enables and serial config slave
// Function
// - register writes override strap scrambler/NRZI defaults
// - remote sense on: training and upstream status
// - no DC-balance: four payload lanes, fifth is valid
// - host holds valid 110 clocks per link
// - valid high with DC-balance sends SYNC
// - host toggles valid periodically without remote sense
// - both straps off: no lane alignment
// - default coding on when straps differ
// - bus ignored while port select low
// - config port works in standby
// - fixed seven bit slave address
// - START and STOP from data while clock high
// - idle after bus-free or clock-high timeout
// - write: address, register, data, each acked
// - read: register, repeated start, data, NACK
// - no address resolution protocol
// - host deselects before talking elsewhere
// - master changes data only while clock low
// - scrambler bit change needs unlock bit
// - NRZI controlled by its own override bit
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module sscp_dev #(
	parameter int T_HIGH_CYC = sscp_pkg::T_HIGH_MAX_CYC
) (
	sscp_if.dev              BUS,
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        REMOTE_SENSE_STRAP_N,
	input  wire logic        DC_BALANCE_STRAP_N,
	input  wire logic        STANDBY,
	output logic             SCRAMBLE_EN,
	output logic             NRZI_EN,
	output logic             DC_BALANCE_EN,
	output logic             TRAINING_EN,
	output logic             UPSTREAM_EN,
	output logic             ALIGN_EN,
	output logic             SYNC_INSERT,
	output logic [4:0]       TX_DATA,
	output logic             BUS_IDLE
);
	logic [9:0]              sync1;
	logic [9:0]              sync2;
	logic                    scl_d;
	logic                    sda_d;
	logic                    rs_strap;
	logic                    dcb_strap;
	logic                    straps_taken;
	logic [7:0]              coding;
	logic [7:0]              unlock;
	logic [15:0]             idle_cnt;
	logic                    after_stop;
	sscp_pkg::sscp_dst_t     state;
	logic [2:0]              bitcnt;
	logic [7:0]              shreg;
	logic [7:0]              reg_addr;
	logic                    second;
	logic                    rd;
	logic                    sda_oe;
	logic                    sda_zero;
	logic                    scl_s;
	logic                    sda_s;
	logic                    cs_s;
	logic [3:0]              lanes_s;
	logic                    valid_s;
	logic                    start;
	logic                    stop;
	logic                    rise;
	logic                    fall;
	logic                    idle_to;
	logic                    byte_in;
	logic [7:0]              shin;
	logic                    wr_now;
	logic                    def_coding;
	logic                    scr_eff;
	logic                    nrzi_eff;
	logic                    bus_free;
	logic [7:0]              rd_now;

	// read-back value; coding bits show the effective enables
	function automatic logic [7:0] rd_val(input logic [7:0] a, input logic [7:0] c,
		input logic [7:0] u, input logic s, input logic n);
		logic [7:0] v;
		v = 8'h00;
		if (a == sscp_pkg::REG_CODING) begin
			v = c;
			v[sscp_pkg::SCR_BIT] = s;
			v[sscp_pkg::NRZI_BIT] = n;
		end else if (a == sscp_pkg::REG_UNLOCK) begin
			v = u;
		end
		return v;
	endfunction

	// two flip-flop synchronisers for the strap and bus pins
	always_ff @(posedge CLK) begin
		sync1 <= {REMOTE_SENSE_STRAP_N, DC_BALANCE_STRAP_N, BUS.valid_lane_input,
			BUS.lane_data, BUS.bus_port_select, BUS.sda, BUS.scl};
		sync2 <= sync1;
	end

	assign scl_s   = sync2[0];
	assign sda_s   = sync2[1];
	assign cs_s    = sync2[2];
	assign lanes_s = sync2[6:3];
	assign valid_s = sync2[7];

	// history of the synchronised bus lines for edge finding
	always_ff @(posedge CLK) begin
		if (SRST) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign start   = cs_s && scl_s && scl_d && sda_d && !sda_s;
	assign stop    = cs_s && scl_s && scl_d && !sda_d && sda_s;
	assign rise    = scl_s && !scl_d;
	assign fall    = !scl_s && scl_d;
	assign shin    = {shreg[6:0], sda_s};
	assign byte_in = rise && (bitcnt == 3'h7) && (state == sscp_pkg::D_RX);
	assign wr_now  = byte_in && second;

	// straps are caught once, just after reset is released
	always_ff @(posedge CLK) begin
		if (SRST) begin
			straps_taken <= 1'b0;
			rs_strap     <= 1'b1;
			dcb_strap    <= 1'b1;
		end else if (!straps_taken) begin
			straps_taken <= 1'b1;
			rs_strap     <= sync2[9];
			dcb_strap    <= sync2[8];
		end
	end

	assign def_coding = rs_strap ^ dcb_strap;
	assign scr_eff  = unlock[sscp_pkg::SCR_UNLK_BIT] ? coding[sscp_pkg::SCR_BIT] : def_coding;
	assign nrzi_eff = unlock[sscp_pkg::NRZI_OVR_BIT] ? coding[sscp_pkg::NRZI_BIT] : def_coding;
	assign rd_now   = rd_val(reg_addr, coding, unlock, scr_eff, nrzi_eff);

	// configuration registers written from the bus
	always_ff @(posedge CLK) begin
		if (SRST) begin
			coding <= sscp_pkg::CODING_RST;
			unlock <= sscp_pkg::UNLOCK_RST;
		end else if (wr_now) begin
			if (reg_addr == sscp_pkg::REG_UNLOCK) begin
				unlock <= shin;
			end else if (reg_addr == sscp_pkg::REG_CODING) begin
				coding <= shin;
				if (!unlock[sscp_pkg::SCR_UNLK_BIT]) begin
					coding[sscp_pkg::SCR_BIT] <= coding[sscp_pkg::SCR_BIT];
				end
			end
		end
	end

	// idle timer: both lines high past bus-free after STOP or past clock-high max
	always_ff @(posedge CLK) begin
		if (SRST || !(scl_s && sda_s)) begin
			idle_cnt <= 16'h0000;
		end else if (idle_cnt != 16'hFFFF) begin
			idle_cnt <= idle_cnt + 16'h0001;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST || start) begin
			after_stop <= 1'b0;
		end else if (stop) begin
			after_stop <= 1'b1;
		end
	end

	assign idle_to = scl_s && sda_s && (after_stop ? (idle_cnt >= 16'(sscp_pkg::T_BUF_CYC))
		: (idle_cnt >= 16'(T_HIGH_CYC)));

	// bus counts as free from reset, and after a start only once the idle timeout has run out
	always_ff @(posedge CLK) begin
		if (SRST) begin
			bus_free <= 1'b1;
		end else if (start) begin
			bus_free <= 1'b0;
		end else if (idle_to) begin
			bus_free <= 1'b1;
		end
	end

	// slave state machine; keeps running in standby
	always_ff @(posedge CLK) begin
		if (SRST || !cs_s) begin
			state  <= sscp_pkg::D_IDLE;
			sda_oe <= 1'b0;
			bitcnt <= 3'h0;
			shreg  <= 8'h00;
			second <= 1'b0;
			rd     <= 1'b0;
		end else if (start) begin
			state  <= sscp_pkg::D_ADDR;
			sda_oe <= 1'b0;
			bitcnt <= 3'h0;
		end else if (stop || idle_to) begin
			state  <= sscp_pkg::D_IDLE;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
			sscp_pkg::D_IDLE, sscp_pkg::D_IGN: begin
				sda_oe <= 1'b0;
			end
			sscp_pkg::D_ADDR: begin
				if (rise) begin
					shreg  <= shin;
					bitcnt <= bitcnt + 3'h1;
					if (bitcnt == 3'h7) begin
						rd <= sda_s;
						if (shreg[6:0] == sscp_pkg::SLAVE_ADDR) begin
							state <= sscp_pkg::D_ACK;
						end else begin
							state <= sscp_pkg::D_IGN;
						end
						if (!sda_s) begin
							second <= 1'b0;
						end
					end
				end
			end
			sscp_pkg::D_RX: begin
				if (rise) begin
					shreg  <= shin;
					bitcnt <= bitcnt + 3'h1;
					if (bitcnt == 3'h7) begin
						state <= sscp_pkg::D_ACK;
						if (!second) begin
							reg_addr <= shin;
						end
						second <= 1'b1;
					end
				end
			end
			sscp_pkg::D_ACK: begin
				if (fall && !sda_oe) begin
					sda_oe <= 1'b1;
				end else if (fall) begin
					bitcnt <= 3'h0;
					if (rd) begin
						state  <= sscp_pkg::D_TX;
						shreg  <= rd_now;
						sda_oe <= !rd_now[7];
					end else begin
						state  <= sscp_pkg::D_RX;
						sda_oe <= 1'b0;
					end
				end
			end
			sscp_pkg::D_TX: begin
				if (fall) begin
					if (bitcnt == 3'h7) begin
						state  <= sscp_pkg::D_MACK;
						sda_oe <= 1'b0;
					end else begin
						bitcnt <= bitcnt + 3'h1;
						shreg  <= {shreg[6:0], 1'b0};
						sda_oe <= !shreg[6];
					end
				end
			end
			sscp_pkg::D_MACK: begin
				if (rise) begin
					state <= sscp_pkg::D_IGN;
				end
			end
			default: begin
				state  <= sscp_pkg::D_IDLE;
				sda_oe <= 1'b0;
			end
			endcase
		end
	end

	// open-drain data line: value stays low, enable decides
	always_ff @(posedge CLK) begin
		sda_zero <= 1'b0;
	end

	assign BUS.sda_d_o  = sda_zero;
	assign BUS.sda_d_oe = sda_oe;

	// mode controls and lane handling toward the datapath
	always_ff @(posedge CLK) begin
		if (SRST) begin
			SCRAMBLE_EN   <= 1'b0;
			NRZI_EN       <= 1'b0;
			DC_BALANCE_EN <= 1'b0;
			TRAINING_EN   <= 1'b0;
			UPSTREAM_EN   <= 1'b0;
			ALIGN_EN      <= 1'b0;
			SYNC_INSERT   <= 1'b0;
			TX_DATA       <= 5'h00;
			BUS_IDLE      <= 1'b1;
		end else begin
			SCRAMBLE_EN   <= scr_eff;
			NRZI_EN       <= nrzi_eff;
			DC_BALANCE_EN <= !dcb_strap;
			TRAINING_EN   <= !rs_strap && !STANDBY;
			UPSTREAM_EN   <= !rs_strap && !STANDBY;
			ALIGN_EN      <= !(rs_strap && dcb_strap);
			SYNC_INSERT   <= !dcb_strap && valid_s && !STANDBY;
			BUS_IDLE      <= bus_free;
			if (STANDBY) begin
				TX_DATA <= 5'h00;
			end else if (!dcb_strap) begin
				TX_DATA <= valid_s ? 5'h00 : {1'b0, lanes_s};
			end else begin
				TX_DATA <= {valid_s, lanes_s};
			end
		end
	end
endmodule

// *** src/sscp_host.sv ***
// host end: APB-controlled serial config master and lane/valid driver
`timescale 1ns/1ps
module sscp_host #(
	parameter int QTR_CYC    = 250,
	parameter int SYNC_PER   = 2000,
	parameter int SYNC_PULSE = 16
) (
	sscp_if.host             BUS,
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	logic [1:0]              sda_sy;
	sscp_pkg::sscp_hst_t     state;
	logic [15:0]             qdiv;
	logic [1:0]              q;
	logic [3:0]              bitn;
	logic [2:0]              bidx;
	logic                    rd;
	logic [7:0]              reg_a;
	logic [7:0]              dat;
	logic [7:0]              rdd;
	logic                    nack;
	logic                    busy;
	logic                    scl_oe;
	logic                    sda_oe;
	logic                    sel;
	logic                    zero;
	logic                    per_en;
	logic [3:0]              lanes;
	logic [6:0]              hold;
	logic [15:0]             per_cnt;
	logic                    valid;
	logic                    tick;
	logic                    acc;
	logic                    go;
	logic [7:0]              txb;

	// byte sent in each slot of a transaction
	function automatic logic [7:0] tx_byte(input logic [2:0] i, input logic [7:0] r,
		input logic [7:0] d);
		unique case (i)
		3'h0:    tx_byte = {sscp_pkg::SLAVE_ADDR, 1'b0};
		3'h1:    tx_byte = r;
		3'h2:    tx_byte = d;
		3'h3:    tx_byte = {sscp_pkg::SLAVE_ADDR, 1'b1};
		default: tx_byte = 8'hFF;
		endcase
	endfunction

	assign acc  = PSEL && PENABLE && PREADY;
	assign go   = acc && PWRITE && (PADDR == sscp_pkg::HR_CMD) && PWDATA[sscp_pkg::CMD_GO] && !busy;
	assign tick = (qdiv == 16'(QTR_CYC - 1));
	assign txb  = tx_byte(bidx, reg_a, dat);

	// sample the shared data line
	always_ff @(posedge CLK) begin
		sda_sy <= {sda_sy[0], BUS.sda};
	end

	// APB slave: no wait state, flopped answer
	always_ff @(posedge CLK) begin
		if (SRST) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && (PADDR[1:0] != 2'h0 || PADDR > sscp_pkg::HR_LANE);
			unique case (PADDR)
			sscp_pkg::HR_STATUS: PRDATA <= {15'h0000, valid, rdd, 6'h00, nack, busy};
			sscp_pkg::HR_LINK:   PRDATA <= {30'h00000000, per_en, 1'b0};
			sscp_pkg::HR_LANE:   PRDATA <= {28'h0000000, lanes};
			default:             PRDATA <= 32'h00000000;
			endcase
		end
	end

	// link and lane settings
	always_ff @(posedge CLK) begin
		if (SRST) begin
			per_en <= 1'b0;
			lanes  <= 4'h0;
		end else if (acc && PWRITE) begin
			if (PADDR == sscp_pkg::HR_LINK) begin
				per_en <= PWDATA[sscp_pkg::LNK_PER];
			end
			if (PADDR == sscp_pkg::HR_LANE) begin
				lanes <= PWDATA[3:0];
			end
		end
	end

	// valid lane: 110-cycle hold on link start, periodic pulses if enabled
	always_ff @(posedge CLK) begin
		if (SRST) begin
			hold    <= 7'h00;
			per_cnt <= 16'h0000;
			valid   <= 1'b0;
		end else begin
			per_cnt <= (per_cnt == 16'(SYNC_PER - 1)) ? 16'h0000 : per_cnt + 16'h0001;
			if (acc && PWRITE && PADDR == sscp_pkg::HR_LINK && PWDATA[sscp_pkg::LNK_START]) begin
				hold <= 7'(sscp_pkg::VALID_HOLD_CYC);
			end else if (per_en && per_cnt == 16'h0000) begin
				hold <= 7'(SYNC_PULSE);
			end else if (hold != 7'h00) begin
				hold <= hold - 7'h01;
			end
			valid <= (hold != 7'h00);
		end
	end

	// quarter-bit divider that paces the bus clock
	always_ff @(posedge CLK) begin
		if (SRST || state == sscp_pkg::H_IDLE || tick) begin
			qdiv <= 16'h0000;
		end else begin
			qdiv <= qdiv + 16'h0001;
		end
	end

	// bus master sequencer
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state  <= sscp_pkg::H_IDLE;
			q      <= 2'h0;
			bitn   <= 4'h0;
			bidx   <= 3'h0;
			rd     <= 1'b0;
			reg_a  <= 8'h00;
			dat    <= 8'h00;
			rdd    <= 8'h00;
			nack   <= 1'b0;
			busy   <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			sel    <= 1'b0;
		end else begin
			unique case (state)
			sscp_pkg::H_IDLE: begin
				if (go) begin
					state <= sscp_pkg::H_SEL;
					sel   <= 1'b1;
					busy  <= 1'b1;
					nack  <= 1'b0;
					rd    <= PWDATA[sscp_pkg::CMD_READ];
					reg_a <= PWDATA[sscp_pkg::CMD_REG_L +: 8];
					dat   <= PWDATA[sscp_pkg::CMD_DAT_L +: 8];
					bidx  <= 3'h0;
					q     <= 2'h0;
				end
			end
			sscp_pkg::H_SEL: begin
				if (tick) begin
					q <= q + 2'h1;
					if (q == 2'h3) begin
						state <= sscp_pkg::H_START;
					end
				end
			end
			sscp_pkg::H_START: begin
				if (tick) begin
					q <= q + 2'h1;
					unique case (q)
					2'h0: sda_oe <= 1'b0;
					2'h1: scl_oe <= 1'b0;
					2'h2: sda_oe <= 1'b1;
					2'h3: begin
						scl_oe <= 1'b1;
						bitn   <= 4'h0;
						state  <= sscp_pkg::H_BIT;
					end
					endcase
				end
			end
			sscp_pkg::H_BIT: begin
				if (tick) begin
					q <= q + 2'h1;
					unique case (q)
					2'h0: sda_oe <= (bitn < 4'h8) && (bidx != 3'h4) && !txb[3'(4'h7 - bitn)];
					2'h1: scl_oe <= 1'b0;
					2'h2: begin
						if (bidx == 3'h4 && bitn < 4'h8) begin
							rdd <= {rdd[6:0], sda_sy[1]};
						end else if (bitn == 4'h8 && bidx != 3'h4 && sda_sy[1]) begin
							nack <= 1'b1;
						end
					end
					2'h3: begin
						scl_oe <= 1'b1;
						bitn   <= bitn + 4'h1;
						if (bitn == 4'h8) begin
							bitn <= 4'h0;
							if (nack || (bidx == 3'h2) || (bidx == 3'h4)) begin
								state <= sscp_pkg::H_STOP;
							end else if (bidx == 3'h1 && rd) begin
								bidx  <= 3'h3;
								state <= sscp_pkg::H_START;
							end else begin
								bidx <= bidx + 3'h1;
							end
						end
					end
					endcase
				end
			end
			sscp_pkg::H_STOP: begin
				if (tick) begin
					q <= q + 2'h1;
					unique case (q)
					2'h0: sda_oe <= 1'b1;
					2'h1: scl_oe <= 1'b0;
					2'h2: sda_oe <= 1'b0;
					2'h3: state  <= sscp_pkg::H_DESEL;
					endcase
				end
			end
			sscp_pkg::H_DESEL: begin
				if (tick) begin
					sel   <= 1'b0;
					busy  <= 1'b0;
					state <= sscp_pkg::H_IDLE;
				end
			end
			default: state <= sscp_pkg::H_IDLE;
			endcase
		end
	end

	// open-drain values stay low; enables decide
	always_ff @(posedge CLK) begin
		zero <= 1'b0;
	end

	assign BUS.scl_o            = zero;
	assign BUS.sda_h_o          = zero;
	assign BUS.scl_oe           = scl_oe;
	assign BUS.sda_h_oe         = sda_oe;
	assign BUS.bus_port_select  = sel;
	assign BUS.lane_data        = lanes;
	assign BUS.valid_lane_input = valid;
endmodule

// *** verification/sscp_sva.sv ***
// concurrent checks on the serial config link between host and serializer ends
`timescale 1ns/1ps
module sscp_sva (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic sda_d_o,
	input wire logic sda_d_oe,
	input wire logic bus_port_select,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	// device stays off the bus while its port is deselected
	a_unsel_quiet: assert property (
		!bus_port_select |-> !sda_d_oe)
		else $error("device drives data line while deselected");
	// device only ever pulls the data line low
	a_dev_open_drain: assert property (
		sda_d_oe |-> !sda_d_o)
		else $error("device drives data line high");
	// device turns its driver on or off only while the clock is low
	a_dev_turn_low: assert property (
		$changed(sda_d_oe) |-> !scl && !$past(scl))
		else $error("device data driver changed with clock high");
	// a start condition is only seen with the port selected
	a_start_select: assert property (
		scl && $past(scl) && $fell(sda) |-> bus_port_select)
		else $error("start condition without port select");
	// a stop condition is only seen with the port selected
	a_stop_select: assert property (
		scl && $past(scl) && $rose(sda) |-> bus_port_select)
		else $error("stop condition without port select");
	// deselect happens only with both lines released
	a_desel_free: assert property (
		$fell(bus_port_select) |-> scl && sda)
		else $error("port deselected in mid transfer");
	// select comes ahead of the start condition
	a_sel_lead: assert property (
		$rose(bus_port_select) |-> (scl && sda) [*8])
		else $error("start too soon after select");
	// each clock high phase lasts two quarters of four cycles
	a_scl_high_len: assert property (
		$rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
endmodule

// *** verification/sscp_bench.sv ***
// self-checking bench: host end drives the serializer end over the config link
`timescale 1ns/1ps
module sscp_bench;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        rs_n = 1'b1;
	logic        dcb_n = 1'b1;
	logic        sb = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scr, nrzi, dcb_en, train, up, align, sync_ins, bus_idle;
	logic [4:0]  tx;
	logic [31:0] st, q;
	logic        perr;
	int          err_count = 0;
	int          comparisons = 0;
	int          cnt;

	sscp_if link ();
	sscp_dev #(.T_HIGH_CYC(600)) sscp_dev_i (.BUS(link), .CLK(clk), .SRST(srst),
		.REMOTE_SENSE_STRAP_N(rs_n), .DC_BALANCE_STRAP_N(dcb_n), .STANDBY(sb),
		.SCRAMBLE_EN(scr), .NRZI_EN(nrzi), .DC_BALANCE_EN(dcb_en), .TRAINING_EN(train),
		.UPSTREAM_EN(up), .ALIGN_EN(align), .SYNC_INSERT(sync_ins), .TX_DATA(tx),
		.BUS_IDLE(bus_idle));
	sscp_host #(.QTR_CYC(4)) sscp_host_i (.BUS(link), .CLK(clk), .SRST(srst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr));
	sscp_sva sscp_sva_i (.CLK(clk), .SRST(srst), .sda_d_o(link.sda_d_o),
		.sda_d_oe(link.sda_d_oe), .bus_port_select(link.bus_port_select),
		.scl(link.scl), .sda(link.sda));

	// free-running system clock
	initial begin
		forever #5 clk = ~clk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask

	task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	// one apb transfer: setup, then access until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			stop_test();
		end
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one serial register transaction, then wait for the link to go idle
	task automatic cmd(input logic rd, input logic [7:0] r, input logic [7:0] d);
		int n;
		apb(1'b1, sscp_pkg::HR_CMD, {8'h00, d, r, 6'h00, rd, 1'b1});
		n = 0;
		do begin
			apb(1'b0, sscp_pkg::HR_STATUS, 32'h00000000);
			st = q;
			n++;
		end while (st[0] !== 1'b0 && n < 600);
		if (n >= 600) begin
			err_count++;
			stop_test();
		end
		chk_bit("nack", 1'b0, st[1]);
		chk_bit("idle_early", 1'b0, bus_idle);
		n = 0;
		while (bus_idle !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		chk_bit("idle_late", 1'b1, bus_idle);
	endtask

	// hang guard
	initial begin
		#600000;
		err_count++;
		stop_test();
	end

	// main sequence: every strap combination, then the scrambler lock
	initial begin
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			rs_n <= i[1];
			dcb_n <= i[0];
			sb <= (i == 3);
			srst <= 1'b1;
			repeat (10) @(posedge clk);
			srst <= 1'b0;
			repeat (10) @(posedge clk);
			chk_bit("scr_dflt", i[1] ^ i[0], scr);
			chk_bit("nrzi_dflt", i[1] ^ i[0], nrzi);
			chk_bit("dcb_en", !i[0], dcb_en);
			chk_bit("training", !i[1], train);
			chk_bit("upstream", !i[1], up);
			chk_bit("align", !(i[1] && i[0]), align);
			apb(1'b1, sscp_pkg::HR_LANE, 32'h0000000A);
			repeat (6) @(posedge clk);
			chk_val("tx_idle", (i == 3) ? 8'h00 : 8'h0A, {3'h0, tx});
			apb(1'b1, sscp_pkg::HR_LINK, 32'h00000001);
			cnt = 0;
			while (link.valid_lane_input !== 1'b1 && cnt < 10) begin
				@(posedge clk);
				cnt++;
			end
			cnt = 0;
			while (link.valid_lane_input === 1'b1 && cnt < 300) begin
				@(posedge clk);
				cnt++;
				if (cnt == 20) begin
					chk_bit("sync", !i[0] && i != 3, sync_ins);
					chk_val("tx_valid", (i == 3 || !i[0]) ? 8'h00 : 8'h1A, {3'h0, tx});
				end
			end
			chk_bit("valid_hold", 1'b1, cnt >= sscp_pkg::VALID_HOLD_CYC);
			cmd(1'b0, sscp_pkg::REG_UNLOCK, 8'h18);
			cmd(1'b0, sscp_pkg::REG_CODING, 8'h90);
			cmd(1'b1, sscp_pkg::REG_CODING, 8'h00);
			chk_val("coding_rd", 8'h90, st[15:8]);
			chk_bit("scr_on", 1'b1, scr);
			chk_bit("nrzi_on", 1'b1, nrzi);
			cmd(1'b0, sscp_pkg::REG_CODING, 8'h00);
			chk_bit("scr_off", 1'b0, scr);
			chk_bit("nrzi_off", 1'b0, nrzi);
		end
		// still strapped off and in standby: scrambler change needs the unlock bit
		cmd(1'b0, sscp_pkg::REG_UNLOCK, 8'h00);
		cmd(1'b0, sscp_pkg::REG_CODING, 8'h10);
		cmd(1'b1, sscp_pkg::REG_CODING, 8'h00);
		chk_val("locked_rd", 8'h00, st[15:8]);
		chk_bit("scr_locked", 1'b0, scr);
		cmd(1'b0, sscp_pkg::REG_UNLOCK, 8'h08);
		cmd(1'b0, sscp_pkg::REG_CODING, 8'h10);
		cmd(1'b1, sscp_pkg::REG_CODING, 8'h00);
		chk_val("unlocked_rd", 8'h10, st[15:8]);
		chk_bit("scr_standby", 1'b1, scr);
		cmd(1'b1, 8'h30, 8'h00);
		chk_val("unused_rd", 8'h00, st[15:8]);
		apb(1'b1, sscp_pkg::HR_LINK, 32'h00000002);
		cnt = 0;
		while (link.valid_lane_input !== 1'b1 && cnt < 2100) begin
			@(posedge clk);
			cnt++;
		end
		chk_bit("sync_pulse", 1'b1, link.valid_lane_input);
		apb(1'b0, 8'h10, 32'h00000000);
		chk_bit("apb_err", 1'b1, perr);
		stop_test();
	end
endmodule
